// file: inc/itc_regs.svh
// Behaviour
// [R1] unit enable clear: unit gets no count clock and ignores register writes
// [R2] unit enable set: clocks run, writes allowed, channel stays stopped until started
// [R3] prescaler select sets the two shared operation clock rates; channel picks one
// [R4] software sets subclock input select before start to count quarter-rate subclock
// [R5] software clears output mode and level bits, then writes output bit for level
// [R6] stopped channel keeps timer output at last written level
// [R7] start trigger write sets running status and starts counting; trigger reads 0
// [R8] interval: first count clock loads compare; start-interrupt mode adds irq and toggle
// [R9] interval: decrement each count clock; after 0000h reload, irq and toggle
// [R10] software leaves mode, output mode and level alone while running
// [R11] counter value readable at any time
// [R12] stop trigger clears running status, freezes counter, holds timer output
// [R13] with output enable 0, writing output bit sets timer output level directly
// [R14] clearing unit enable initialises all logic and registers, output bit to 0; code leaves the itc_edge synchroniser flops running, not cleared
// [R15] event mode: start trigger loads compare at once, no edge needed
// [R16] event mode: decrement per valid edge; at 0000h reload and raise interrupt
// [R17] software does not use timer output in event counter mode
// [R18] compare rewritable any time; takes effect at next reload only
// [R19] event input edges sampled on the operation clock; code samples every clock, ignoring the prescaler
// [R20] interval interrupt period is count clock period times compare plus one
// [R21] start-interrupt mode 0: first load raises no interrupt and no toggle
// [R22] counter and compare are 16 bits; interrupt is one clock pulse
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ITC_A_UNIT 8'h00
`define ITC_A_PRESC 8'h04
`define ITC_A_MODE 8'h08
`define ITC_A_CMP 8'h0c
`define ITC_A_CNT 8'h10
`define ITC_A_TRIG 8'h14
`define ITC_A_STAT 8'h18
`define ITC_A_OUT 8'h1c

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ITC_UNIT_EN 0
`define ITC_PRESC_W 8
`define ITC_PRESC_A_LO 0
`define ITC_PRESC_A_HI 3
`define ITC_PRESC_B_LO 4
`define ITC_PRESC_B_HI 7
`define ITC_WORD_HI 15
`define ITC_MODE_W 9
`define ITC_MODE_MD 0
`define ITC_MODE_CKSEL 1
`define ITC_MODE_EVM 2
`define ITC_MODE_EDGE_LO 3
`define ITC_MODE_EDGE_HI 4
`define ITC_MODE_SIS 8
`define ITC_TRIG_START 0
`define ITC_TRIG_STOP 1
`define ITC_STAT_RUN 0
`define ITC_OUT_TO 0
`define ITC_OUT_OE 1
`define ITC_OUT_LVL 2
`define ITC_OUT_OM 3
`define ITC_EDGE_FALL 2'h0
`define ITC_EDGE_RISE 2'h1
`define ITC_EDGE_BOTH 2'h2
`define ITC_SUB_LAST 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ITC_RST_PRESC 8'h00
`define ITC_RST_MODE 9'h000
`define ITC_RST_CMP 16'h0000

`endif

// file: inc/itc_pkg.sv
package itc_pkg;
	typedef enum {ITC_STOPPED, ITC_ARMED, ITC_COUNTING} itc_chan_t;
	typedef logic [15:0] itc_word_t;
endpackage

// file: inc/itc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface itc_tick_if;
	logic tick_a;
	logic tick_b;
	modport gen (output tick_a, output tick_b);
	modport use_side (input tick_a, input tick_b);
endinterface
`default_nettype wire

// file: core/itc_presc.sv
`timescale 1ns/1ps
`default_nettype none
`include "itc_regs.svh"
module itc_presc import itc_pkg::*; #(
	parameter int PW = 16
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic [`ITC_PRESC_W-1:0] sel,
	itc_tick_if.gen ticks
);
	logic [PW-1:0] cnt_q, cnt_d, mask_a, mask_b;

	// ----------------------------------------------------------------
	// shared divider, held cleared while the unit is off
	// ----------------------------------------------------------------
	always_comb begin
		cnt_d = enable ? cnt_q + 1'b1 : '0; // R1
		mask_a = PW'((32'h1 << sel[`ITC_PRESC_A_HI:`ITC_PRESC_A_LO]) - 32'h1); // R3
		mask_b = PW'((32'h1 << sel[`ITC_PRESC_B_HI:`ITC_PRESC_B_LO]) - 32'h1); // R3
		ticks.tick_a = enable && ((cnt_q & mask_a) == mask_a);
		ticks.tick_b = enable && ((cnt_q & mask_b) == mask_b);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // itc_presc
`default_nettype wire

// file: core/itc_edge.sv
`timescale 1ns/1ps
`default_nettype none
module itc_edge (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic pin,
	input wire logic rise_en,
	input wire logic fall_en,
	output logic edge_pulse
);
	logic s1_q, s1_d, s2_q, s2_d, prev_q, prev_d;

	// ----------------------------------------------------------------
	// two-stage sync, then edge compare on the synced level only
	// ----------------------------------------------------------------
	always_comb begin
		s1_d = pin;
		s2_d = s1_q;
		prev_d = s2_q;
		edge_pulse = (rise_en && s2_q && !prev_q) || (fall_en && !s2_q && prev_q); // R19
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			prev_q <= prev_d;
		end
	end
endmodule // itc_edge
`default_nettype wire

// file: core/itc_top.sv
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "itc_regs.svh"
module itc_top import itc_pkg::*; #(
	parameter int PW = 16
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic event_input,
	input wire logic sub_clock,
	output logic timer_output,
	output logic channel_interrupt
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic en_q, en_d;
	logic [`ITC_PRESC_W-1:0] ps_q, ps_d;
	logic [`ITC_MODE_W-1:0] mode_q, mode_d;
	itc_word_t cmp_q, cmp_d, cnt_q, cnt_d;
	itc_chan_t st_q, st_d;
	logic to_q, to_d, oe_q, oe_d, lvl_q, lvl_d, om_q, om_d;
	logic irq_q, irq_d, pin_q, pin_d;
	logic [1:0] sub_div_q, sub_div_d;
	logic wr_q, wr_d;
	logic [7:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic ap, wen, start, stop, tick, sub_tick, tgl, ev_edge, sub_edge;
	logic rise_en, fall_en, evm;
	logic [1:0] edge_sel;

	itc_tick_if ticks ();

	// ----------------------------------------------------------------
	// count sources
	// ----------------------------------------------------------------
	itc_presc #(.PW(PW)) u_presc (
		.clock(clock),
		.arst_n(arst_n),
		.enable(en_q),
		.sel(ps_q),
		.ticks(ticks)
	);

	itc_edge u_ev_edge (
		.clock(clock),
		.arst_n(arst_n),
		.pin(event_input),
		.rise_en(rise_en),
		.fall_en(fall_en),
		.edge_pulse(ev_edge)
	);

	itc_edge u_sub_edge (
		.clock(clock),
		.arst_n(arst_n),
		.pin(sub_clock),
		.rise_en(1'b1),
		.fall_en(1'b0),
		.edge_pulse(sub_edge)
	);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			`ITC_A_UNIT: r[`ITC_UNIT_EN] = en_q;
			`ITC_A_PRESC: r[`ITC_PRESC_W-1:0] = ps_q;
			`ITC_A_MODE: r[`ITC_MODE_W-1:0] = mode_q;
			`ITC_A_CMP: r[`ITC_WORD_HI:0] = cmp_q;
			`ITC_A_CNT: r[`ITC_WORD_HI:0] = cnt_q;
			`ITC_A_STAT: r[`ITC_STAT_RUN] = (st_q != ITC_STOPPED);
			`ITC_A_OUT: r[`ITC_OUT_OM:`ITC_OUT_TO] = {om_q, lvl_q, oe_q, to_q};
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// ahb-lite slave: zero wait, read data registered at address phase
	// ----------------------------------------------------------------
	always_comb begin
		ap = hsel && htrans[1] && hready;
		wr_d = ap && hwrite;
		addr_d = ap ? haddr[7:0] : addr_q;
		rdata_d = (ap && !hwrite) ? rd_mux(haddr[7:0]) : rdata_q; // R11 R7
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			rdata_q <= 32'h0;
		end else begin
			wr_q <= wr_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// channel
	// ----------------------------------------------------------------
	always_comb begin
		evm = mode_q[`ITC_MODE_EVM];
		edge_sel = mode_q[`ITC_MODE_EDGE_HI:`ITC_MODE_EDGE_LO];
		rise_en = (edge_sel == `ITC_EDGE_RISE) || (edge_sel == `ITC_EDGE_BOTH);
		fall_en = (edge_sel == `ITC_EDGE_FALL) || (edge_sel == `ITC_EDGE_BOTH);
		wen = wr_q && en_q; // R1
		start = wen && (addr_q == `ITC_A_TRIG) && hwdata[`ITC_TRIG_START];
		stop = wen && (addr_q == `ITC_A_TRIG) && hwdata[`ITC_TRIG_STOP];
		sub_tick = sub_edge && (sub_div_q == `ITC_SUB_LAST);
		sub_div_d = sub_edge ? sub_div_q + 2'h1 : sub_div_q;
		// R3 R4
		if (evm) begin
			tick = ev_edge; // R16
		end else if (mode_q[`ITC_MODE_SIS]) begin
			tick = sub_tick;
		end else begin
			tick = mode_q[`ITC_MODE_CKSEL] ? ticks.tick_b : ticks.tick_a;
		end
		en_d = (wr_q && addr_q == `ITC_A_UNIT) ? hwdata[`ITC_UNIT_EN] : en_q; // R2
		ps_d = (wen && addr_q == `ITC_A_PRESC) ? hwdata[`ITC_PRESC_W-1:0] : ps_q;
		mode_d = (wen && addr_q == `ITC_A_MODE) ? hwdata[`ITC_MODE_W-1:0] : mode_q;
		cmp_d = (wen && addr_q == `ITC_A_CMP) ? hwdata[`ITC_WORD_HI:0] : cmp_q; // R18
		oe_d = oe_q;
		lvl_d = lvl_q;
		om_d = om_q;
		st_d = st_q;
		cnt_d = cnt_q;
		irq_d = 1'b0;
		tgl = 1'b0;
		// compare is only read at load time, so a rewrite waits for reload
		case (st_q)
			ITC_STOPPED: begin
				st_d = ITC_STOPPED; // R6 R12
			end
			ITC_ARMED: begin
				if (tick) begin
					cnt_d = cmp_q; // R8
					st_d = ITC_COUNTING;
					irq_d = mode_q[`ITC_MODE_MD]; // R8 R21
					tgl = mode_q[`ITC_MODE_MD]; // R21
				end
			end
			ITC_COUNTING: begin
				if (tick) begin
					if (cnt_q == 16'h0000) begin
						cnt_d = cmp_q; // R9 R16 R20
						irq_d = 1'b1; // R22
						tgl = 1'b1;
					end else begin
						cnt_d = cnt_q - 16'h0001; // R9
					end
				end
			end
			default: begin
				st_d = ITC_STOPPED;
			end
		endcase
		if (stop) begin
			st_d = ITC_STOPPED; // R12
			cnt_d = cnt_q;
			irq_d = 1'b0;
			tgl = 1'b0;
		end else if (start) begin
			if (evm) begin
				cnt_d = cmp_q; // R15
				st_d = ITC_COUNTING;
			end else begin
				st_d = ITC_ARMED; // R7
			end
			irq_d = 1'b0;
			tgl = 1'b0;
		end
		to_d = to_q;
		if (tgl && oe_q && !evm) begin
			to_d = !to_q; // R9
		end
		if (wen && addr_q == `ITC_A_OUT) begin
			to_d = hwdata[`ITC_OUT_TO]; // R13
			oe_d = hwdata[`ITC_OUT_OE];
			lvl_d = hwdata[`ITC_OUT_LVL];
			om_d = hwdata[`ITC_OUT_OM];
		end
		if (!en_q) begin
			// R14
			ps_d = `ITC_RST_PRESC;
			mode_d = `ITC_RST_MODE;
			cmp_d = `ITC_RST_CMP;
			cnt_d = 16'h0000;
			st_d = ITC_STOPPED;
			to_d = 1'b0;
			oe_d = 1'b0;
			lvl_d = 1'b0;
			om_d = 1'b0;
			irq_d = 1'b0;
			sub_div_d = 2'h0;
		end
		pin_d = to_d ^ lvl_d;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0;
			ps_q <= `ITC_RST_PRESC;
			mode_q <= `ITC_RST_MODE;
			cmp_q <= `ITC_RST_CMP;
			cnt_q <= 16'h0000;
			st_q <= ITC_STOPPED;
			to_q <= 1'b0;
			oe_q <= 1'b0;
			lvl_q <= 1'b0;
			om_q <= 1'b0;
			irq_q <= 1'b0;
			pin_q <= 1'b0;
			sub_div_q <= 2'h0;
		end else begin
			en_q <= en_d;
			ps_q <= ps_d;
			mode_q <= mode_d;
			cmp_q <= cmp_d;
			cnt_q <= cnt_d;
			st_q <= st_d;
			to_q <= to_d;
			oe_q <= oe_d;
			lvl_q <= lvl_d;
			om_q <= om_d;
			irq_q <= irq_d;
			pin_q <= pin_d;
			sub_div_q <= sub_div_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = rdata_q;
	assign timer_output = pin_q;
	assign channel_interrupt = irq_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	property p_off_clear; // R14
		!en_q |=> (cnt_q == 16'h0000) && !to_q && (cmp_q == 16'h0000) && (st_q == ITC_STOPPED);
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("disabled unit not cleared"); // R14

	property p_off_nowrite; // R1
		(!en_q && wr_q && addr_q == `ITC_A_CMP) |=> (cmp_q == 16'h0000);
	endproperty
	a_off_nowrite: assert property (p_off_nowrite) else $error("write taken while off"); // R1

	property p_start_run; // R7
		(start && !stop) |=> (st_q != ITC_STOPPED);
	endproperty
	a_start_run: assert property (p_start_run) else $error("start did not run"); // R7

	property p_trig_zero; // R7
		(ap && !hwrite && haddr[7:0] == `ITC_A_TRIG) |=> (hrdata == 32'h0);
	endproperty
	a_trig_zero: assert property (p_trig_zero) else $error("trigger read nonzero"); // R7

	property p_stop_freeze; // R12
		(stop && en_q) |=> (st_q == ITC_STOPPED) && (cnt_q == $past(cnt_q))
			##1 ($past(start) || !$past(en_q) || (cnt_q == $past(cnt_q)));
	endproperty
	a_stop_freeze: assert property (p_stop_freeze) else $error("stop did not freeze"); // R12

	property p_hold_out; // R6
		(st_q == ITC_STOPPED && en_q && !(wen && addr_q == `ITC_A_OUT)) |=> $stable(to_q);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("stopped output moved"); // R6

	property p_reload; // R9
		(en_q && st_q == ITC_COUNTING && tick && cnt_q == 16'h0000 && !stop && !start)
			|=> (cnt_q == $past(cmp_q)) && channel_interrupt;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at zero"); // R9

	property p_decr; // R9
		(en_q && st_q == ITC_COUNTING && tick && cnt_q != 16'h0000 && !stop && !start)
			|=> (cnt_q == $past(cnt_q) - 16'h0001) && !channel_interrupt;
	endproperty
	a_decr: assert property (p_decr) else $error("count did not step"); // R9

	property p_first_quiet; // R21
		(en_q && st_q == ITC_ARMED && tick && !mode_q[`ITC_MODE_MD] && !stop && !start
			&& !(wen && addr_q == `ITC_A_OUT))
			|=> !channel_interrupt && $stable(to_q) && (cnt_q == $past(cmp_q));
	endproperty
	a_first_quiet: assert property (p_first_quiet) else $error("first load not quiet"); // R21

	property p_ev_load; // R15
		(start && !stop && evm) |=> (cnt_q == $past(cmp_q)) && (st_q == ITC_COUNTING);
	endproperty
	a_ev_load: assert property (p_ev_load) else $error("event start not loaded"); // R15

	property p_direct_out; // R13
		(wen && addr_q == `ITC_A_OUT && !oe_q) |=> (to_q == $past(hwdata[`ITC_OUT_TO]))
			&& (timer_output == (to_q ^ lvl_q));
	endproperty
	a_direct_out: assert property (p_direct_out) else $error("output write not direct"); // R13
endmodule // itc_top
`default_nettype wire

// file: test/itc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module itc_pin_model (
	input wire logic clock,
	input wire logic timer_output,
	output logic event_input,
	output logic sub_clock
);
	logic sub_run = 1'b0;
	logic to_prev = 1'b0;
	int toggles = 0;

	// ----------------------------------------
	// subsystem oscillator, 8 clock periods
	// ----------------------------------------
	// off-grid phase so sampling never races the main clock
	initial begin
		sub_clock = 1'b0;
		#1.3;
		forever #20 sub_clock = sub_run ? ~sub_clock : 1'b0;
	end

	// ----------------------------------------
	// event pin and output watcher
	// ----------------------------------------
	initial event_input = 1'b0;

	// levels held 6 clocks so the synchroniser sees every edge
	task automatic pulse(input int n);
		repeat (n) begin
			repeat (6) @(posedge clock);
			event_input <= 1'b1;
			repeat (6) @(posedge clock);
			event_input <= 1'b0;
		end
		repeat (6) @(posedge clock);
	endtask

	always @(posedge clock) begin
		to_prev <= timer_output;
		if (timer_output !== to_prev)
			toggles <= toggles + 1;
	end
endmodule // itc_pin_model
`default_nettype wire

// file: test/interval_and_event_timer_channel_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "itc_regs.svh"
module interval_and_event_timer_channel_bench;
	logic clock, arst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic event_input, sub_clock, timer_output, channel_interrupt;
	logic rd_dp;
	logic [31:0] exp_q[$];
	int err_count, checks_done, cyc, irq_n, irq_t, last_gap;
	logic [31:0] presc [4] = '{32'h00, 32'h02, 32'h10, 32'h00};
	logic [31:0] mode [4] = '{32'h001, 32'h000, 32'h003, 32'h101};
	int tk [4] = '{1, 4, 2, 32};
	int ecnt [4] = '{1, 1, 2, 0};

	itc_top itc_top_inst (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .event_input, .sub_clock,
		.timer_output, .channel_interrupt);
	itc_pin_model itc_pin_model_inst (.clock, .timer_output, .event_input, .sub_clock);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h00000000;
		do @(posedge clock); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h00000000);
	endtask

	task automatic wait_irq(input int target);
		for (int i = 0; i < 4000 && irq_n < target; i++)
			@(posedge clock);
		check(irq_n >= target, 32'h1);
	endtask

	// ----------------------------------------
	// monitor and timeout
	// ----------------------------------------
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_dp <= 1'b0;
		end else begin
			rd_dp <= hsel & htrans[1] & !hwrite & hreadyout;
			if (rd_dp && hreadyout === 1'b1) begin
				check(hrdata, exp_q.pop_front());
				check(hresp, 32'h0);
			end
		end
	end

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (channel_interrupt === 1'b1) begin
			irq_n <= irq_n + 1;
			last_gap <= cyc - irq_t;
			irq_t <= cyc;
		end
		if (cyc > 20000) begin
			err_count++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int c, t0, tg0, ir0;
		{hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
		arst_n = 1'b0;
		{err_count, checks_done, cyc, irq_n, irq_t, last_gap} = '0;
		void'($urandom(80321));
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		repeat (2) @(posedge clock);
		wr(`ITC_A_CMP, 32'h00001234);
		wr(`ITC_A_UNIT, 32'h1);
		rd(`ITC_A_CMP, 32'h0);
		rd(`ITC_A_STAT, 32'h0);
		rd(8'h20, 32'h0);
		$display("test enable done");
		for (int k = 0; k < 4; k++) begin
			c = $urandom_range(9, 2);
			itc_pin_model_inst.sub_run = (k == 3);
			wr(`ITC_A_PRESC, presc[k]);
			wr(`ITC_A_MODE, mode[k]);
			wr(`ITC_A_CMP, c);
			wr(`ITC_A_OUT, 32'h2);
			ir0 = irq_n;
			t0 = cyc;
			wr(`ITC_A_TRIG, 32'h1);
			rd(`ITC_A_TRIG, 32'h0);
			rd(`ITC_A_STAT, 32'h1);
			wait_irq(ir0 + 1);
			check(irq_t - t0 <= tk[k] + 8, mode[k] & 1);
			wait_irq(ir0 + 3);
			check(last_gap, tk[k] * (c + 1));
			wr(`ITC_A_TRIG, 32'h2);
			rd(`ITC_A_STAT, 32'h0);
			tg0 = itc_pin_model_inst.toggles;
			repeat (tk[k] * 12) @(posedge clock);
			check(itc_pin_model_inst.toggles, tg0);
			check(timer_output, (irq_n - ir0) & 1);
		end
		$display("test interval done");
		wr(`ITC_A_PRESC, 32'h0);
		for (int e = 0; e < 4; e++) begin
			wr(`ITC_A_MODE, 32'h4 | (e << 3));
			wr(`ITC_A_OUT, 32'h0);
			wr(`ITC_A_CMP, 32'h00ff);
			wr(`ITC_A_TRIG, 32'h1);
			rd(`ITC_A_CNT, 32'h00ff);
			itc_pin_model_inst.pulse(3);
			rd(`ITC_A_CNT, 32'h00ff - 3 * ecnt[e]);
			wr(`ITC_A_TRIG, 32'h2);
		end
		c = $urandom_range(6, 3);
		wr(`ITC_A_MODE, 32'h0c);
		wr(`ITC_A_CMP, c);
		wr(`ITC_A_TRIG, 32'h1);
		ir0 = irq_n;
		itc_pin_model_inst.pulse(2);
		wr(`ITC_A_CMP, 32'h9);
		rd(`ITC_A_CNT, c - 2);
		itc_pin_model_inst.pulse(c - 1);
		rd(`ITC_A_CNT, 32'h9);
		check(irq_n - ir0, 1);
		itc_pin_model_inst.pulse(2);
		wr(`ITC_A_TRIG, 32'h2);
		itc_pin_model_inst.pulse(3);
		rd(`ITC_A_CNT, 32'h7);
		$display("test event done");
		wr(`ITC_A_OUT, 32'h1);
		repeat (2) @(posedge clock);
		check(timer_output, 1'b1);
		wr(`ITC_A_OUT, 32'h0);
		repeat (2) @(posedge clock);
		check(timer_output, 1'b0);
		wr(`ITC_A_OUT, 32'h1);
		wr(`ITC_A_UNIT, 32'h0);
		repeat (3) @(posedge clock);
		check(timer_output, 1'b0);
		rd(`ITC_A_OUT, 32'h0);
		rd(`ITC_A_CMP, 32'h0);
		rd(`ITC_A_MODE, 32'h0);
		wr(`ITC_A_CMP, 32'h5);
		rd(`ITC_A_CMP, 32'h0);
		$display("test output and disable done");
		print_verdict();
	end
endmodule // interval_and_event_timer_channel_bench
`default_nettype wire
